// ===== rtl/tstc_pkg.sv
// package: register map, field positions and types for the timer status/trigger block
package tstc_pkg;
  // register indices on the plain register port
  localparam logic [1:0] ADDR_FLAG_OUT = 2'h0;
  localparam logic [1:0] ADDR_TRIG_CLK = 2'h1;
  localparam logic [1:0] ADDR_MAIN_CTL = 2'h2;
  localparam int ADDR_W = 2;
  // flag/output-select register fields
  localparam int BIT_MATCH_B = 7;
  localparam int BIT_MATCH_A = 6;
  localparam int BIT_OVF = 5;
  localparam int BIT_FO_RSV = 4;
  localparam int FLD_ACT_B_LO = 2;
  localparam int FLD_ACT_A_LO = 0;
  // trigger/clock control fields
  localparam int FLD_EDGE_LO = 3;
  localparam int BIT_TRIG_EN = 2;
  localparam int BIT_REFINE = 0;
  localparam logic [7:0] TRIG_RSV_MASK = 8'he2;
  // main control fields
  localparam int BIT_IE_B = 7;
  localparam int BIT_IE_A = 6;
  localparam int BIT_IE_OVF = 5;
  localparam int FLD_CLR_LO = 3;
  localparam int FLD_CKS_LO = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] CONST_RESET = 8'hff;
  localparam int DIV_W = 7;

  // output action per match
  typedef enum logic [1:0] {
    TSTC_ACT_KEEP = 2'h0,
    TSTC_ACT_LOW = 2'h1,
    TSTC_ACT_HIGH = 2'h2,
    TSTC_ACT_TOGGLE = 2'h3
  } tstc_act_t;

  // trigger edge choice
  typedef enum logic [1:0] {
    TSTC_EDGE_OFF = 2'h0,
    TSTC_EDGE_RISE = 2'h1,
    TSTC_EDGE_FALL = 2'h2,
    TSTC_EDGE_BOTH = 2'h3
  } tstc_edge_t;

  // counter clear source
  typedef enum logic [1:0] {
    TSTC_CLR_NONE = 2'h0,
    TSTC_CLR_A = 2'h1,
    TSTC_CLR_B = 2'h2,
    TSTC_CLR_PIN = 2'h3
  } tstc_clr_t;

  // events of the counter in one cycle
  typedef struct packed {
    logic match_a;
    logic match_b;
    logic overflow;
  } tstc_evt_t;
endpackage

// ===== rtl/tstc_timer.sv
// timer with status flags, waveform output, trigger start/stop and clock select
`timescale 1ns/1ns

// ==========================================================================
// timer core
// ==========================================================================
// How it works
// - set match-B flag (bit 7) when count equals constant B
// - set match-A flag (bit 6) when count equals constant A
// - set overflow flag (bit 5) when count wraps from ff to 00
// - a flag clears only on writing 0 after it was read as 1
// - status bit 4 always reads as 1
// - match B drives output per bits 3:2: keep, low, high, toggle
// - match A drives output per bits 1:0 with the same encoding
// - actions for A and B are independent, each from its own field
// - after reset the output is low until the first match
// - trigger edge from bits 4:3: off, rising, falling, both
// - trigger enabled: halt after match clear, start on selected edge
// - trigger disabled: no start from edges and no halt after clear
// - trigger register bits 7:5 and bit 1 read as 1
// - refine bit 0 combines with 3-bit clock select for counter clock
// - internal codes pick div 4/8, 16/32, 64/128; count on falling edge
// - after a halt, counting resumes on the selected trigger edge
// - simultaneous matches resolve toggle over high over low
// - interrupt for each flag only while its enable bit is 1
module tstc_timer #(
  parameter int CNT_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [tstc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [CNT_W-1:0] count_value,
  input wire logic [CNT_W-1:0] constant_a,
  input wire logic [CNT_W-1:0] constant_b,
  input wire logic trigger_in,
  input wire logic ext_clk_in,
  output logic count_tick,
  output logic count_clear,
  output logic waveform_out,
  output logic irq_match_a,
  output logic irq_match_b,
  output logic irq_overflow
);

  // ========================================================================
  // helpers
  // ========================================================================
  // one match action applied to a level
  function automatic logic apply_act(input tstc_pkg::tstc_act_t a, input logic cur);
    logic r;
    r = cur;
    unique case (a)
      tstc_pkg::TSTC_ACT_KEEP: r = cur;
      tstc_pkg::TSTC_ACT_LOW: r = 1'b0;
      tstc_pkg::TSTC_ACT_HIGH: r = 1'b1;
      tstc_pkg::TSTC_ACT_TOGGLE: r = ~cur;
    endcase
    return r;
  endfunction

  // edge detect against a selection code
  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
    logic rise;
    logic fall;
    rise = now & ~was;
    fall = ~now & was;
    return (sel[0] & rise) | (sel[1] & fall);
  endfunction

  // ========================================================================
  // pin synchronisers
  // ========================================================================
  logic [1:0] trig_sync_q, trig_sync_d;
  logic trig_prev_q, trig_prev_d;
  logic [1:0] ext_sync_q, ext_sync_d;
  logic ext_prev_q, ext_prev_d;

  // two stages before any logic looks at a pin
  always_comb begin
    trig_sync_d = {trig_sync_q[0], trigger_in};
    trig_prev_d = trig_sync_q[1];
    ext_sync_d = {ext_sync_q[0], ext_clk_in};
    ext_prev_d = ext_sync_q[1];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trig_sync_q <= 2'h0;
      trig_prev_q <= 1'b0;
      ext_sync_q <= 2'h0;
      ext_prev_q <= 1'b0;
    end else begin
      trig_sync_q <= trig_sync_d;
      trig_prev_q <= trig_prev_d;
      ext_sync_q <= ext_sync_d;
      ext_prev_q <= ext_prev_d;
    end
  end

  // ========================================================================
  // registers
  // ========================================================================
  logic [2:0] flags_q, flags_d; // {match_b, match_a, overflow}
  logic [2:0] seen_q, seen_d; // flag was read as 1
  logic [3:0] act_sel_q, act_sel_d;
  logic [1:0] edge_sel_q, edge_sel_d;
  logic trig_en_q, trig_en_d;
  logic refine_q, refine_d;
  logic [7:0] main_ctl_q, main_ctl_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] flag_reg_view;
  logic [7:0] trig_reg_view;
  tstc_pkg::tstc_evt_t evt;
  logic [2:0] evt_vec;
  logic wr_fo;

  // register views; reserved bits forced to 1
  always_comb begin
    flag_reg_view = tstc_pkg::REG_RESET;
    flag_reg_view[tstc_pkg::BIT_MATCH_B] = flags_q[2];
    flag_reg_view[tstc_pkg::BIT_MATCH_A] = flags_q[1];
    flag_reg_view[tstc_pkg::BIT_OVF] = flags_q[0];
    flag_reg_view[tstc_pkg::BIT_FO_RSV] = 1'b1;
    flag_reg_view[tstc_pkg::FLD_ACT_A_LO+:4] = act_sel_q;
    trig_reg_view = tstc_pkg::TRIG_RSV_MASK;
    trig_reg_view[tstc_pkg::FLD_EDGE_LO+:2] = edge_sel_q;
    trig_reg_view[tstc_pkg::BIT_TRIG_EN] = trig_en_q;
    trig_reg_view[tstc_pkg::BIT_REFINE] = refine_q;
  end

  // flag set/clear and control writes; set beats clear in the same cycle
  always_comb begin
    evt_vec = {evt.match_b, evt.match_a, evt.overflow};
    wr_fo = reg_wr && (reg_addr == tstc_pkg::ADDR_FLAG_OUT);
    flags_d = flags_q;
    seen_d = seen_q;
    act_sel_d = act_sel_q;
    edge_sel_d = edge_sel_q;
    trig_en_d = trig_en_q;
    refine_d = refine_q;
    main_ctl_d = main_ctl_q;
    rdata_d = tstc_pkg::REG_RESET;
    if (reg_rd) begin
      unique case (reg_addr)
        tstc_pkg::ADDR_FLAG_OUT: begin
          rdata_d = flag_reg_view;
          seen_d = seen_q | flags_q; // arm the clear
        end
        tstc_pkg::ADDR_TRIG_CLK: rdata_d = trig_reg_view;
        tstc_pkg::ADDR_MAIN_CTL: rdata_d = main_ctl_q;
        default: rdata_d = tstc_pkg::REG_RESET; // unmapped reads zero
      endcase
    end
    if (wr_fo) begin
      // clear only where written 0 and armed by an earlier read of 1
      flags_d = flags_q & ~(seen_q & ~reg_wdata[tstc_pkg::BIT_OVF+:3]);
      seen_d = 3'h0;
      act_sel_d = reg_wdata[tstc_pkg::FLD_ACT_A_LO+:4];
    end
    if (reg_wr && reg_addr == tstc_pkg::ADDR_TRIG_CLK) begin
      edge_sel_d = reg_wdata[tstc_pkg::FLD_EDGE_LO+:2];
      trig_en_d = reg_wdata[tstc_pkg::BIT_TRIG_EN];
      refine_d = reg_wdata[tstc_pkg::BIT_REFINE];
    end
    if (reg_wr && reg_addr == tstc_pkg::ADDR_MAIN_CTL) begin
      main_ctl_d = reg_wdata;
    end
    flags_d = flags_d | evt_vec;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_q <= 3'h0;
      seen_q <= 3'h0;
      act_sel_q <= 4'h0;
      edge_sel_q <= 2'h0;
      trig_en_q <= 1'b0;
      refine_q <= 1'b0;
      main_ctl_q <= tstc_pkg::REG_RESET;
      rdata_q <= tstc_pkg::REG_RESET;
    end else begin
      flags_q <= flags_d;
      seen_q <= seen_d;
      act_sel_q <= act_sel_d;
      edge_sel_q <= edge_sel_d;
      trig_en_q <= trig_en_d;
      refine_q <= refine_d;
      main_ctl_q <= main_ctl_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // each flag gated by its own enable
  assign irq_match_b = flags_q[2] & main_ctl_q[tstc_pkg::BIT_IE_B];
  assign irq_match_a = flags_q[1] & main_ctl_q[tstc_pkg::BIT_IE_A];
  assign irq_overflow = flags_q[0] & main_ctl_q[tstc_pkg::BIT_IE_OVF];

  // ========================================================================
  // clock select and count tick
  // ========================================================================
  localparam int DIV_W_L = tstc_pkg::DIV_W;
  logic [DIV_W_L-1:0] div_q, div_d;
  logic int_clk_q, int_clk_d;
  logic halted_q, halted_d;
  logic [2:0] cks;
  logic src_tick;
  logic trig_hit;
  tstc_pkg::tstc_clr_t clr_sel;

  // internal tap: code 1/2/3 -> div 4,16,64; refine picks the slower neighbour
  always_comb begin
    logic [2:0] tap;
    tap = 3'h0;
    cks = main_ctl_q[tstc_pkg::FLD_CKS_LO+:3];
    div_d = div_q + 1'b1;
    // codes 0 and 4 keep tap at 0 so the index never leaves the divider
    if (cks[1:0] != 2'h0) begin
      tap = 3'((2 * cks[1:0]) - 1) + 3'(refine_q);
    end
    int_clk_d = div_q[tap];
    src_tick = 1'b0;
    if (!cks[2]) begin
      // falling edge of the divided clock, so a source switch may add a tick
      src_tick = (cks[1:0] != 2'h0) & int_clk_q & ~int_clk_d;
    end else begin
      src_tick = edge_hit(cks[1:0], ext_sync_q[1], ext_prev_q);
    end
  end

  // counter clear from the chosen match, trigger start and halt
  always_comb begin
    clr_sel = tstc_pkg::tstc_clr_t'(main_ctl_q[tstc_pkg::FLD_CLR_LO+:2]);
    trig_hit = edge_hit(edge_sel_q, trig_sync_q[1], trig_prev_q);
    count_clear = (clr_sel == tstc_pkg::TSTC_CLR_A && evt.match_a) ||
                  (clr_sel == tstc_pkg::TSTC_CLR_B && evt.match_b);
    halted_d = halted_q;
    if (!trig_en_q) begin
      halted_d = 1'b0;
    end else if (count_clear) begin
      halted_d = 1'b1;
    end else if (trig_hit) begin
      halted_d = 1'b0;
    end
    count_tick = src_tick & ~halted_q & ~count_clear;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      int_clk_q <= 1'b0;
      halted_q <= 1'b0;
    end else begin
      div_q <= div_d;
      int_clk_q <= int_clk_d;
      halted_q <= halted_d;
    end
  end

  // ========================================================================
  // events and waveform output
  // ========================================================================
  logic wave_q, wave_d;
  logic [CNT_W-1:0] last_cnt_q, last_cnt_d;
  logic cnt_valid_q, cnt_valid_d;
  tstc_pkg::tstc_act_t act_a, act_b, act_win;

  // match fires once per new count value; overflow when ff goes to 00
  always_comb begin
    last_cnt_d = count_value;
    cnt_valid_d = 1'b1;
    evt.match_a = (count_value == constant_a) &&
                  (!cnt_valid_q || last_cnt_q != count_value);
    evt.match_b = (count_value == constant_b) &&
                  (!cnt_valid_q || last_cnt_q != count_value);
    evt.overflow = cnt_valid_q && last_cnt_q == CNT_W'(tstc_pkg::COUNT_MAX) &&
                   count_value == '0;
  end

  // each field drives its own match; toggle beats high beats low
  always_comb begin
    act_a = evt.match_a ? tstc_pkg::tstc_act_t'(act_sel_q[1:0]) : tstc_pkg::TSTC_ACT_KEEP;
    act_b = evt.match_b ? tstc_pkg::tstc_act_t'(act_sel_q[3:2]) : tstc_pkg::TSTC_ACT_KEEP;
    act_win = (act_a > act_b) ? act_a : act_b;
    wave_d = apply_act(act_win, wave_q);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wave_q <= 1'b0;
      last_cnt_q <= '0;
      cnt_valid_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
      last_cnt_q <= last_cnt_d;
      cnt_valid_q <= cnt_valid_d;
    end
  end

  assign waveform_out = wave_q;

endmodule

// ===== testbench/tstc_timer_asserts.sv
// checker: port-level assertions for the timer status/trigger block
`timescale 1ns/1ns
// ========
// checker
module tstc_timer_asserts #(
  parameter int CNT_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [tstc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [CNT_W-1:0] count_value,
  input wire logic [CNT_W-1:0] constant_a,
  input wire logic [CNT_W-1:0] constant_b,
  input wire logic waveform_out,
  input wire logic irq_match_a,
  input wire logic irq_match_b,
  input wire logic irq_overflow
);
  // one clock domain, so one default clock and reset
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  chk_status_rsv_one: assert property (reg_rd && reg_addr == 2'h0 |=> reg_rdata[4])
    else $error("status bit 4 read as 0");
  chk_trig_rsv_ones: assert property (reg_rd && reg_addr == 2'h1 |=> &reg_rdata[7:5] && reg_rdata[1])
    else $error("trigger reserved bits read as 0");
  chk_wave_cause: assert property (waveform_out != $past(waveform_out) |-> $past(count_value == constant_a || count_value == constant_b))
    else $error("output moved without a match");
  chk_wave_reset_low: assert property ($fell(rst) |-> !waveform_out && !irq_match_a)
    else $error("output not low after reset");
  chk_irqb_cause: assert property ($rose(irq_match_b) |-> $past(count_value == constant_b) || $past(reg_wr))
    else $error("match b raised without cause");
  chk_ovf_cause: assert property ($rose(irq_overflow) |-> $past(reg_wr) || ($past(count_value) == '0 && $past(count_value, 2) == '1))
    else $error("overflow raised without wrap");
  chk_irqa_hold: assert property (irq_match_a && !reg_wr |=> irq_match_a)
    else $error("match a dropped without a write");
  chk_irqb_clear: assert property ($fell(irq_match_b) |-> $past(reg_wr))
    else $error("match b dropped without a write");
  // main scenarios reached
  cover property ($rose(waveform_out));
  cover property ($rose(irq_match_a));
  cover property ($rose(irq_overflow));
endmodule

// ===== testbench/tstc_timer_tb.sv
// testbench: register and pin scenarios for the timer status/trigger block
`timescale 1ns/1ns
// ========
// bench
module tstc_timer_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, count_value = 8'h05, constant_a = 8'h40, constant_b = 8'h80;
  logic trigger_in = 1'b0;
  logic count_tick, count_clear, waveform_out, irq_match_a, irq_match_b, irq_overflow;
  logic [2:0] ext_div = 3'h0;
  // clock select codes and ticks expected in 128 cycles: internal, off, external
  logic [7:0] cks_set [11] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h03, 8'h03, 8'h00,
    8'h04, 8'h05, 8'h06, 8'h07};
  logic [7:0] tick_exp [11] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00,
    8'h00, 8'h10, 8'h10, 8'h20};
  logic w = 1'b0;
  logic [1:0] c;
  // trigger cases: enable, edge mode, start level, resume expected
  logic [4:0] tc [6] = '{5'b00101, 5'b10000, 5'b10101, 5'b10110, 5'b11011, 5'b11101};
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int t;
  // 50 MHz
  always #10 mclk = ~mclk;
  // external count clock at mclk/8: 16 rises and 16 falls per 128 cycles
  always @(posedge mclk) ext_div <= ext_div + 3'h1;
  tstc_timer #(.CNT_W(8)) u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_value(count_value), .constant_a(constant_a), .constant_b(constant_b),
    .trigger_in(trigger_in), .ext_clk_in(ext_div[2]), .count_tick(count_tick),
    .count_clear(count_clear),
    .waveform_out(waveform_out), .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
    .irq_overflow(irq_overflow));
  task automatic wrap_up();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  // strobe then a gap cycle, so no strobe is driven twice in one step
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk("reg", e, reg_rdata);
    @(posedge mclk);
  endtask
  // one cycle of equality, then away to a value matching nothing
  task automatic hit(input logic [7:0] v);
    count_value <= v;
    @(posedge mclk);
    count_value <= 8'h05;
    repeat (3) @(posedge mclk);
  endtask
  task automatic cnt(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(negedge mclk);
      if (count_tick === 1'b1) k++;
    end
    @(posedge mclk);
  endtask
  // hang guard, far above the few thousand cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("wave", 8'h00, 8'(waveform_out));
    rd(2'h0, 8'h10);
    rd(2'h1, 8'he2);
    rd(2'h2, 8'h00);
    wr(2'h0, 8'hff);
    rd(2'h0, 8'h1f);
    // window of 128 cycles holds a whole number of every divided or external period
    for (int i = 0; i < 11; i++) begin
      wr(2'h1, {7'h00, i[0]});
      wr(2'h2, cks_set[i]);
      repeat (8) @(posedge mclk);
      cnt(128, t);
      chk("ticks", tick_exp[i], 8'(t));
    end
    // a runs 3,0,1,2 from low, b runs 0,3,2,1 from high: every action shows
    for (int s = 0; s < 2; s++) begin
      for (int i = 3; i < 7; i++) begin
        c = (s == 1) ? 2'(3 - i) : 2'(i);
        wr(2'h0, (s == 1) ? {4'h0, c, ~c} : {4'h0, ~c, c});
        hit((s == 1) ? constant_b : constant_a);
        w = (c == 2'h0) ? w : (c == 2'h3) ? ~w : c[1];
        chk("wave", 8'(w), 8'(waveform_out));
      end
    end
    constant_b <= constant_a;
    wr(2'h0, 8'h07);
    hit(constant_a);
    chk("wave", 8'h01, 8'(waveform_out));
    wr(2'h0, 8'h06);
    hit(constant_a);
    chk("wave", 8'h01, 8'(waveform_out));
    constant_b <= 8'h80;
    wr(2'h2, 8'h80);
    chk("irq_b", 8'h01, 8'(irq_match_b));
    rd(2'h0, 8'hd6);
    wr(2'h0, 8'h06);
    rd(2'h0, 8'h16);
    hit(constant_a);
    wr(2'h0, 8'h06);
    rd(2'h0, 8'h56);
    wr(2'h2, 8'h40);
    chk("irq_a", 8'h01, 8'(irq_match_a));
    wr(2'h2, 8'h20);
    chk("irq_a", 8'h00, 8'(irq_match_a));
    count_value <= 8'hff;
    @(posedge mclk);
    count_value <= 8'h00;
    @(posedge mclk);
    count_value <= 8'h05;
    repeat (3) @(posedge mclk);
    chk("irq_ovf", 8'h01, 8'(irq_overflow));
    rd(2'h0, 8'h76);
    // clear on match b pulses only in the cycle of a new match
    wr(2'h2, 8'h10);
    count_value <= constant_b;
    @(negedge mclk);
    chk("clear", 8'h01, 8'(count_clear));
    @(posedge mclk);
    @(negedge mclk);
    chk("clear", 8'h00, 8'(count_clear));
    @(posedge mclk);
    count_value <= 8'h05;
    // clear on match a, divide by 4
    wr(2'h2, 8'h09);
    foreach (tc[k]) begin
      trigger_in <= tc[k][1];
      wr(2'h1, {3'h7, tc[k][3:2], tc[k][4], 2'h0});
      repeat (6) @(posedge mclk);
      hit(constant_a);
      cnt(32, t);
      chk("halt", tc[k][4] ? 8'h00 : 8'h08, 8'(t));
      trigger_in <= ~tc[k][1];
      cnt(64, t);
      chk("run", 8'(tc[k][0]), 8'(t != 0));
    end
    wrap_up();
  end
endmodule
bind tstc_timer tstc_timer_asserts #(.CNT_W(CNT_W)) u_chk (.mclk(mclk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .count_value(count_value), .constant_a(constant_a), .constant_b(constant_b),
  .waveform_out(waveform_out), .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
  .irq_overflow(irq_overflow));
